// [hdl/dma_addr_gen.sv]
// three channel dma address generator with apb register slave
module dma_addr_gen
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // requests from video and sound subsystems
  input wire logic video_req,
  input wire logic cursor_req,
  input wire logic sound_req,
  input wire logic vertical_retrace_period,
  // memory bus
  input wire logic bus_busy,
  input wire logic fetch_done,
  output logic fetch_valid,
  output logic [27:0] fetch_addr,
  output logic [1:0] fetch_chan,
  // sound status
  output logic sound_int_flag,
  output logic sound_overrun
);

  function automatic logic [27:0] qinc(input logic [27:0] a);
    qinc = a + dma_pkg::QUAD_STEP;
  endfunction : qinc

  function automatic logic [27:0] sinc(input logic [27:0] a);
    sinc = {a[27:12], a[11:0] + dma_pkg::SND_STEP};
  endfunction : sinc

  logic rst_s1_r;
  logic rst_n_s;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_s <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_s <= rst_s1_r;
    end
  end

  // register state
  logic duplex_r, ven_r, sen_r;
  logic [27:0] vstart_r, vend_r, initb_r, cura_r, curb_r, cinit_r, ccur_r;
  logic [28:0] inita_r;
  logic lasta_r, lastb_r, vsel_b_r;
  logic [27:0] scura_r, scurb_r, senda_r, sendb_r;
  logic slasta_r, slastb_r, stopa_r, stopb_r, proga_r, progb_r;
  logic s_ovr_r, s_int_r, s_ab_r, s_idle_r;
  dma_pkg::fetch_state_e fe_r;
  logic [27:0] fetch_addr_r;
  logic [1:0] fetch_chan_r;

  // bus decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_vctrl = paddr == dma_pkg::OFF_VCTRL;
  wire hit_vstart = paddr == dma_pkg::OFF_VSTART;
  wire hit_vend = paddr == dma_pkg::OFF_VEND;
  wire hit_inita = paddr == dma_pkg::OFF_VINITA;
  wire hit_initb = paddr == dma_pkg::OFF_VINITB;
  wire hit_cura = paddr == dma_pkg::OFF_VCURA;
  wire hit_curb = paddr == dma_pkg::OFF_VCURB;
  wire hit_cinit = paddr == dma_pkg::OFF_CINIT;
  wire hit_ccur = paddr == dma_pkg::OFF_CCUR;
  wire hit_sctrl = paddr == dma_pkg::OFF_SCTRL;
  wire hit_scura = paddr == dma_pkg::OFF_SCURA;
  wire hit_senda = paddr == dma_pkg::OFF_SENDA;
  wire hit_scurb = paddr == dma_pkg::OFF_SCURB;
  wire hit_sendb = paddr == dma_pkg::OFF_SENDB;
  wire hit_sstat = paddr == dma_pkg::OFF_SSTAT;
  wire [27:0] wptr = {pwdata[27:4], 4'h0};
  wire wr_senda = wr & hit_senda;
  wire wr_sendb = wr & hit_sendb;
  wire [2:0] sstat = {s_ovr_r, s_int_r, s_ab_r};

  logic [31:0] rdata;
  logic hit_any;
  always_comb
  begin
    rdata = 32'h00000000;
    hit_any = 1'b1;
    if (hit_vctrl) rdata = {24'h000000, duplex_r, 1'b0, ven_r, 5'h00};
    else if (hit_vstart) rdata = {4'h0, vstart_r};
    else if (hit_vend) rdata = {4'h0, vend_r};
    else if (hit_inita) rdata = {1'b0, inita_r[28], 2'h0, inita_r[27:0]};
    else if (hit_initb) rdata = {4'h0, initb_r};
    else if (hit_cura) rdata = {4'h0, cura_r};
    else if (hit_curb) rdata = {4'h0, curb_r};
    else if (hit_cinit) rdata = {4'h0, cinit_r};
    else if (hit_ccur) rdata = {4'h0, ccur_r};
    else if (hit_sctrl) rdata = {31'h00000000, sen_r};
    else if (hit_scura) rdata = {4'h0, scura_r};
    else if (hit_senda) rdata = {stopa_r, slasta_r, 2'h0, senda_r};
    else if (hit_scurb) rdata = {4'h0, scurb_r};
    else if (hit_sendb) rdata = {stopb_r, slastb_r, 2'h0, sendb_r};
    else if (hit_sstat) rdata = {29'h00000000, sstat};
    else hit_any = 1'b0;
  end

  assign pready = 1'b1;
  assign pslverr = acc & ~hit_any;
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s) prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite) prdata <= rdata;
  end

  // software written configuration
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      duplex_r <= 1'b0;
      ven_r <= 1'b0;
      sen_r <= 1'b0;
      vstart_r <= 28'h0000000;
      vend_r <= 28'h0000000;
      inita_r <= 29'h00000000;
      initb_r <= 28'h0000000;
      cinit_r <= 28'h0000000;
    end
    else if (wr)
    begin
      if (hit_vctrl) duplex_r <= pwdata[dma_pkg::VCTRL_DUPLEX];
      if (hit_vctrl) ven_r <= pwdata[dma_pkg::VCTRL_EN];
      if (hit_sctrl) sen_r <= pwdata[dma_pkg::SCTRL_EN];
      if (hit_vstart) vstart_r <= wptr;
      if (hit_vend) vend_r <= wptr;
      if (hit_inita) inita_r <= {pwdata[dma_pkg::LAST_BIT], wptr};
      if (hit_initb) initb_r <= wptr;
      if (hit_cinit) cinit_r <= wptr;
    end
  end

  // arbitration, video first, then cursor, then sound
  wire snd_run = sen_r & ~s_ovr_r & ~s_idle_r;
  wire want_v = ven_r & video_req;
  wire want_c = ven_r & cursor_req;
  wire want_s = snd_run & sound_req;
  wire can_start = (fe_r == dma_pkg::FE_IDLE) & ~bus_busy;
  wire use_b = duplex_r & vsel_b_r;
  wire [27:0] vaddr = use_b ? curb_r : cura_r;
  wire [27:0] saddr = s_ab_r ? scurb_r : scura_r;
  wire done = (fe_r == dma_pkg::FE_BUSY) & fetch_done;
  wire done_v = done & (fetch_chan_r == dma_pkg::CH_VIDEO);
  wire done_c = done & (fetch_chan_r == dma_pkg::CH_CURSOR);
  wire done_s = done & (fetch_chan_r == dma_pkg::CH_SOUND);
  wire retrace = vertical_retrace_period;

  // each grant is one quad word: four 32-bit words from any bank
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      fe_r <= dma_pkg::FE_IDLE;
      fetch_addr_r <= 28'h0000000;
      fetch_chan_r <= dma_pkg::CH_VIDEO;
    end
    else
    begin
      case (fe_r)
        dma_pkg::FE_IDLE:
        begin
          if (can_start & want_v)
          begin
            fe_r <= dma_pkg::FE_BUSY;
            fetch_addr_r <= vaddr;
            fetch_chan_r <= dma_pkg::CH_VIDEO;
          end
          else if (can_start & want_c)
          begin
            fe_r <= dma_pkg::FE_BUSY;
            fetch_addr_r <= ccur_r;
            fetch_chan_r <= dma_pkg::CH_CURSOR;
          end
          else if (can_start & want_s)
          begin
            fe_r <= dma_pkg::FE_BUSY;
            fetch_addr_r <= saddr;
            fetch_chan_r <= dma_pkg::CH_SOUND;
          end
        end
        dma_pkg::FE_BUSY:
        begin
          if (fetch_done) fe_r <= dma_pkg::FE_IDLE;
        end
        default: fe_r <= dma_pkg::FE_IDLE;
      endcase
    end
  end

  assign fetch_valid = fe_r == dma_pkg::FE_BUSY;
  assign fetch_addr = fetch_addr_r;
  assign fetch_chan = fetch_chan_r;

  // video and cursor current pointers
  wire [27:0] cur_act = use_b ? curb_r : cura_r;
  wire last_act = use_b ? lastb_r : lasta_r;
  wire [27:0] cur_nxt = last_act ? vstart_r : qinc(cur_act);
  wire last_nxt = last_act ? (vstart_r == vend_r) : (qinc(cur_act) == vend_r);
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      cura_r <= 28'h0000000;
      curb_r <= 28'h0000000;
      lasta_r <= 1'b0;
      lastb_r <= 1'b0;
      vsel_b_r <= 1'b0;
      ccur_r <= 28'h0000000;
    end
    else if (retrace)
    begin
      cura_r <= inita_r[27:0];
      lasta_r <= inita_r[28];
      curb_r <= initb_r;
      lastb_r <= initb_r == vend_r;
      vsel_b_r <= 1'b0;
      ccur_r <= cinit_r;
    end
    else
    begin
      if (done_v & ~use_b) cura_r <= cur_nxt;
      if (done_v & ~use_b) lasta_r <= last_nxt;
      if (done_v & use_b) curb_r <= cur_nxt;
      if (done_v & use_b) lastb_r <= last_nxt;
      if (done_v) vsel_b_r <= duplex_r & ~vsel_b_r;
      if (done_c) ccur_r <= qinc(ccur_r);
    end
  end

  // sound pointers, stepping only the low 12 bits
  wire s_last = s_ab_r ? slastb_r : slasta_r;
  wire fin = done_s & s_last;
  wire fin_a = fin & ~s_ab_r;
  wire fin_b = fin & s_ab_r;
  wire stop_act = s_ab_r ? stopb_r : stopa_r;
  wire other_ok = s_ab_r ? (proga_r | wr_senda) : (progb_r | wr_sendb);
  wire [27:0] sa_inc = sinc(scura_r);
  wire [27:0] sb_inc = sinc(scurb_r);
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      scura_r <= 28'h0000000;
      scurb_r <= 28'h0000000;
      senda_r <= 28'h0000000;
      sendb_r <= 28'h0000000;
      slasta_r <= 1'b0;
      slastb_r <= 1'b0;
      stopa_r <= 1'b0;
      stopb_r <= 1'b0;
    end
    else
    begin
      if (wr & hit_scura) scura_r <= wptr;
      else if (done_s & ~s_ab_r & ~slasta_r) scura_r <= sa_inc;
      if (wr & hit_scurb) scurb_r <= wptr;
      else if (done_s & s_ab_r & ~slastb_r) scurb_r <= sb_inc;
      if (wr_senda) senda_r <= wptr;
      if (wr_sendb) sendb_r <= wptr;
      if (wr_senda) slasta_r <= pwdata[dma_pkg::LAST_BIT];
      else if (done_s & ~s_ab_r) slasta_r <= sa_inc[11:0] == senda_r[11:0];
      if (wr_sendb) slastb_r <= pwdata[dma_pkg::LAST_BIT];
      else if (done_s & s_ab_r) slastb_r <= sb_inc[11:0] == sendb_r[11:0];
      if (wr_senda) stopa_r <= pwdata[dma_pkg::STOP_BIT];
      if (wr_sendb) stopb_r <= pwdata[dma_pkg::STOP_BIT];
    end
  end

  // sound state machine; s_ovr_r, s_int_r and s_ab_r are the status flags, s_idle_r is not readable
  wire halted = s_ovr_r | s_idle_r;
  always_ff @(posedge clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      {s_ovr_r, s_int_r, s_ab_r} <= dma_pkg::SSTAT_RESET;
      s_idle_r <= 1'b0;
      proga_r <= 1'b0;
      progb_r <= 1'b0;
    end
    else
    begin
      if (wr_senda) proga_r <= 1'b1;
      else if (fin_a) proga_r <= 1'b0;
      if (wr_sendb) progb_r <= 1'b1;
      else if (fin_b) progb_r <= 1'b0;
      if (fin)
      begin
        s_int_r <= 1'b1;
        s_idle_r <= stop_act;
        s_ovr_r <= ~stop_act & ~other_ok;
        if (~stop_act & other_ok) s_ab_r <= ~s_ab_r;
      end
      else if (wr_senda | wr_sendb)
      begin
        s_int_r <= 1'b0;
        s_ovr_r <= 1'b0;
        s_idle_r <= 1'b0;
        if (halted) s_ab_r <= wr_sendb;
      end
    end
  end

  assign sound_int_flag = s_int_r;
  assign sound_overrun = s_ovr_r;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_s);

  fetch_align_a: assert property (fetch_valid |-> fetch_addr[3:0] == 4'h0)
    else $error("fetch address not quad aligned");
  video_first_a: assert property (can_start && want_v |=> fetch_valid
    && fetch_chan == dma_pkg::CH_VIDEO)
    else $error("video request not granted first");
  grant_wait_a: assert property ($rose(fetch_valid) |-> !$past(bus_busy))
    else $error("grant taken during a bus cycle");
  sound_last_a: assert property ($rose(fetch_valid) && fetch_chan == dma_pkg::CH_SOUND
    |-> !$past(want_v) && !$past(want_c))
    else $error("sound granted over video or cursor");
  video_off_a: assert property (!ven_r && !fetch_valid |=> !fetch_valid
    || fetch_chan == dma_pkg::CH_SOUND)
    else $error("video or cursor fetch while disabled");
  vid_step_a: assert property (done_v && !duplex_r && !lasta_r && !retrace
    |=> cura_r == qinc($past(cura_r)))
    else $error("video pointer did not step by 16");
  vid_wrap_a: assert property (done_v && !duplex_r && lasta_r && !retrace
    |=> cura_r == vstart_r)
    else $error("video pointer did not wrap to start");
  retrace_load_a: assert property (retrace |=> cura_r == $past(inita_r[27:0])
    && ccur_r == $past(cinit_r))
    else $error("retrace reload missed");
  duplex_alt_a: assert property (done_v && duplex_r && !retrace
    |=> vsel_b_r != $past(vsel_b_r))
    else $error("duplex set did not alternate");
  curs_step_a: assert property (done_c && !retrace
    |=> ccur_r == qinc($past(ccur_r)))
    else $error("cursor pointer did not step by 16");
  snd_page_a: assert property (done_s && !wr
    |=> scura_r[27:12] == $past(scura_r[27:12])
    && scurb_r[27:12] == $past(scurb_r[27:12]))
    else $error("sound pointer left its page");
  snd_idle_a: assert property (!sen_r && !fetch_valid |=> !fetch_valid
    || fetch_chan != dma_pkg::CH_SOUND)
    else $error("sound fetch while disabled");
  snd_ovr_a: assert property (fin && !stop_act && !other_ok
    |=> s_ovr_r && s_int_r && !snd_run)
    else $error("overrun not flagged");
  snd_swap_a: assert property (fin && !stop_act && other_ok
    |=> s_int_r && s_ab_r != $past(s_ab_r))
    else $error("buffer swap missed");
  snd_stop_a: assert property (fin && stop_act |=> !snd_run && s_int_r)
    else $error("stop bit did not idle");

  dup_cov: cover property (done_v && duplex_r ##[1:40] done_v && duplex_r);
  swap_cov: cover property (fin && other_ok && !stop_act);
  ovr_cov: cover property (fin && !other_ok && !stop_act);
  wrap_cov: cover property (done_v && lasta_r);

endmodule : dma_addr_gen

// [hdl/dma_pkg.sv]
// constants for the video, cursor and sound dma address generator
// Function
// - every fetch moves four 32-bit words
// - control bit7 duplex, bit5 enable
// - retrace copies init A into current A
// - after video fetch add 16, compare end
// - one more fetch then reload start
// - all pointers quad word aligned
// - video wins bus after current cycle
// - duplex alternates between pointer sets A, B
// - cursor uses video enable, no end
// - cursor pointer adds 16 per fetch
// - cursor fetch gives two raster lines
// - sound pointers step in 4KB page
// - sound granted only without enabled video/cursor requests
// - sound machine idle while disabled
// - state bits read as status, reset 110
// - end pointer write triggers transition
// - stop bit idles after buffer
// - buffer end interrupts, swaps to other pair
// - unprogrammed other pair sets overrun, halts
package dma_pkg;
  localparam int ADDR_W = 28;
  localparam int WORDS_PER_FETCH = 4;
  localparam logic [27:0] QUAD_STEP = 28'h0000010;
  localparam logic [11:0] SND_STEP = 12'h010;
  localparam logic [31:0] OFF_VCTRL = 32'h032001E0;
  localparam logic [31:0] OFF_VSTART = 32'h032001C4;
  localparam logic [31:0] OFF_VEND = 32'h032001C8;
  localparam logic [31:0] OFF_VINITA = 32'h032001CC;
  localparam logic [31:0] OFF_VINITB = 32'h032001D0;
  localparam logic [31:0] OFF_VCURA = 32'h032001D4;
  localparam logic [31:0] OFF_VCURB = 32'h032001D8;
  localparam logic [31:0] OFF_CINIT = 32'h032001DC;
  localparam logic [31:0] OFF_CCUR = 32'h032001E4;
  localparam logic [31:0] OFF_SCTRL = 32'h03200200;
  localparam logic [31:0] OFF_SCURA = 32'h03200204;
  localparam logic [31:0] OFF_SENDA = 32'h03200208;
  localparam logic [31:0] OFF_SCURB = 32'h0320020C;
  localparam logic [31:0] OFF_SENDB = 32'h03200210;
  localparam logic [31:0] OFF_SSTAT = 32'h03200214;
  localparam int VCTRL_DUPLEX = 7;
  localparam int VCTRL_EN = 5;
  localparam int SCTRL_EN = 0;
  localparam int LAST_BIT = 30;
  localparam int STOP_BIT = 31;
  localparam logic [2:0] SSTAT_RESET = 3'h6;
  localparam logic [1:0] CH_VIDEO = 2'h0;
  localparam logic [1:0] CH_CURSOR = 2'h1;
  localparam logic [1:0] CH_SOUND = 2'h2;
  typedef enum logic {FE_IDLE, FE_BUSY} fetch_state_e;
endpackage : dma_pkg

// [tb/far_side.sv]
// far side model: memory responder and bus holder
module far_side
(
  // clock
  input wire logic clk,
  // control from bench
  input wire logic [2:0] lat,
  input wire logic hold,
  // memory bus
  input wire logic fetch_valid,
  output logic fetch_done,
  output logic bus_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt = 3'h0;
  initial fetch_done = 1'b0;
  // another master holds the bus now and then
  assign bus_busy = hold;
  // one done pulse per quad word, after a varying delay
  always @(posedge clk)
  begin
    fetch_done <= 1'b0;
    if (!fetch_valid || fetch_done)
      cnt <= 3'h0;
    else if (cnt >= lat)
      fetch_done <= 1'b1;
    else
      cnt <= cnt + 3'h1;
  end
endmodule : far_side

// [tb/testbench.sv]
// self-checking bench for the dma address generator
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, seed = 32'h53;
  logic pready, pslverr, fetch_valid, fetch_done, bus_busy, fv_q = 1'b0;
  logic video_req = 1'b0, cursor_req = 1'b0, sound_req = 1'b0, vertical_retrace_period = 1'b0;
  logic [27:0] fetch_addr;
  logic [1:0] fetch_chan;
  logic sound_int_flag, sound_overrun, hold = 1'b0;
  logic [2:0] lat = 3'h1;
  logic [29:0] fq[$];
  logic [32:0] rq[$];
  int fail_count = 0, n_compared = 0, cyc = 0;

  always #25 clk = ~clk;

  dma_addr_gen dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .video_req(video_req), .cursor_req(cursor_req),
    .sound_req(sound_req), .vertical_retrace_period(vertical_retrace_period),
    .bus_busy(bus_busy), .fetch_done(fetch_done), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .fetch_chan(fetch_chan), .sound_int_flag(sound_int_flag),
    .sound_overrun(sound_overrun));
  far_side peer (.clk(clk), .lat(lat), .hold(hold), .fetch_valid(fetch_valid),
    .fetch_done(fetch_done), .bus_busy(bus_busy));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : check

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic err);
    rq.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic run(input logic v, input logic c, input logic s, input int n);
    int k;
    k = 0;
    video_req <= v;
    cursor_req <= c;
    sound_req <= s;
    while (k < n)
    begin
      @(posedge clk);
      if (fetch_done === 1'b1)
        k++;
    end
    video_req <= 1'b0;
    cursor_req <= 1'b0;
    sound_req <= 1'b0;
  endtask : run

  task automatic retrace;
    @(posedge clk);
    vertical_retrace_period <= 1'b1;
    @(posedge clk);
    vertical_retrace_period <= 1'b0;
  endtask : retrace

  task automatic quiet_sound;
    sound_req <= 1'b1;
    repeat (8) @(posedge clk);
    sound_req <= 1'b0;
  endtask : quiet_sound

  task automatic flags(input logic [1:0] e);
    @(posedge clk);
    check({sound_overrun, sound_int_flag} === e, "sound flags");
  endtask : flags

  // monitor: every fetch start and every read completion takes the oldest note
  always @(posedge clk)
  begin
    fv_q <= fetch_valid;
    if (fetch_valid === 1'b1 && fv_q !== 1'b1)
      if (fq.size() == 0)
        check(1'b0, "unexpected fetch");
      else
        check({fetch_chan, fetch_addr} === fq.pop_front(), "fetch address");
    if (psel && penable && !pwrite && pready === 1'b1 && rq.size() > 0)
      check({pslverr, prdata} === rq.pop_front(), "read data");
  end

  // random bus holding and memory latency, plus the hang guard
  always @(posedge clk)
  begin
    seed = xs(seed);
    hold <= (seed[1:0] == 2'h0);
    lat <= seed[4:2];
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(dma_pkg::OFF_SSTAT, 32'h6, 1'b0);
    flags(2'b11);
    rd(32'h03200300, 32'h0, 1'b1);
    vertical_retrace_period <= 1'b1;
    apb(1'b1, dma_pkg::OFF_VSTART, 32'h100);
    apb(1'b1, dma_pkg::OFF_VEND, 32'h120);
    apb(1'b1, dma_pkg::OFF_VINITA, 32'h110);
    apb(1'b1, dma_pkg::OFF_VINITB, 32'h0);
    apb(1'b1, dma_pkg::OFF_CINIT, 32'h800);
    apb(1'b1, dma_pkg::OFF_VCTRL, 32'h20);
    retrace();
    fq.push_back({dma_pkg::CH_VIDEO, 28'h110});
    run(1'b1, 1'b1, 1'b0, 1);
    fq.push_back({dma_pkg::CH_VIDEO, 28'h120});
    fq.push_back({dma_pkg::CH_VIDEO, 28'h100});
    run(1'b1, 1'b0, 1'b0, 2);
    apb(1'b1, dma_pkg::OFF_VCURA, 32'hFFF0);
    rd(dma_pkg::OFF_VCURA, 32'h110, 1'b0);
    vertical_retrace_period <= 1'b1;
    apb(1'b1, dma_pkg::OFF_VINITA, 32'h40000120);
    retrace();
    fq.push_back({dma_pkg::CH_VIDEO, 28'h120});
    fq.push_back({dma_pkg::CH_VIDEO, 28'h100});
    run(1'b1, 1'b0, 1'b0, 2);
    fq.push_back({dma_pkg::CH_CURSOR, 28'h800});
    fq.push_back({dma_pkg::CH_CURSOR, 28'h810});
    run(1'b0, 1'b1, 1'b0, 2);
    vertical_retrace_period <= 1'b1;
    apb(1'b1, dma_pkg::OFF_VINITA, 32'h10F);
    apb(1'b1, dma_pkg::OFF_VINITB, 32'h200);
    apb(1'b1, dma_pkg::OFF_VEND, 32'h300);
    apb(1'b1, dma_pkg::OFF_VCTRL, 32'hA0);
    retrace();
    fq.push_back({dma_pkg::CH_VIDEO, 28'h100});
    fq.push_back({dma_pkg::CH_VIDEO, 28'h200});
    fq.push_back({dma_pkg::CH_VIDEO, 28'h110});
    fq.push_back({dma_pkg::CH_VIDEO, 28'h210});
    run(1'b1, 1'b0, 1'b0, 4);
    fq.push_back({dma_pkg::CH_CURSOR, 28'h800});
    run(1'b0, 1'b1, 1'b0, 1);
    apb(1'b1, dma_pkg::OFF_SCURA, 32'h1FF0);
    apb(1'b1, dma_pkg::OFF_SENDA, 32'h1000);
    quiet_sound();
    apb(1'b1, dma_pkg::OFF_SCTRL, 32'h1);
    fq.push_back({dma_pkg::CH_CURSOR, 28'h810});
    run(1'b0, 1'b1, 1'b1, 1);
    fq.push_back({dma_pkg::CH_SOUND, 28'h1FF0});
    fq.push_back({dma_pkg::CH_SOUND, 28'h1000});
    run(1'b0, 1'b0, 1'b1, 2);
    flags(2'b11);
    quiet_sound();
    apb(1'b1, dma_pkg::OFF_SCURB, 32'h2040);
    apb(1'b1, dma_pkg::OFF_SENDB, 32'h40002040);
    flags(2'b00);
    apb(1'b1, dma_pkg::OFF_SCURA, 32'h3000);
    apb(1'b1, dma_pkg::OFF_SENDA, 32'hC0003000);
    fq.push_back({dma_pkg::CH_SOUND, 28'h2040});
    run(1'b0, 1'b0, 1'b1, 1);
    flags(2'b01);
    fq.push_back({dma_pkg::CH_SOUND, 28'h3000});
    run(1'b0, 1'b0, 1'b1, 1);
    flags(2'b01);
    quiet_sound();
    check(fq.size() == 0 && rq.size() == 0, "notes left over");
    results();
  end
endmodule : testbench
